// [src/dscd_pkg.sv]
/*
 * Constants, command codes, request types and pin carrier for the host side
 * controller of an eight channel serial converter command decoder.
 * Assumes a single core clock at 100 MHz; the serial clock is derived from it.
 */
// Functional notes
// RULE1: Code-to-all, wide variant: code bits 23:8.
// RULE2: Code-to-all, narrow variant: code bits 23:12.
// RULE3: 0x79 writes code everywhere, updates all.
// RULE4: 0x7A loads settings 19:8 into all.
// RULE5: 0x7B loads settings and updates all.
// RULE6: 0x7C carries no data, updates all.
// RULE7: Per-channel update refreshes addressed channel only.
// RULE8: Read 0x8/channel returns adjusted channel code.
// RULE9: Read 0x9/channel returns channel settings.
// RULE10: Read 0xA/channel returns offset adjustment.
// RULE11: Read 0xB/channel returns gain adjustment.
// RULE12: 0xF0-0xF2 read config, sleep, input select.
// RULE13: 0xF3, 0xF4 read toggle, toggle enable.
// RULE14: 0xF5 reads analog multiplexer control.
// RULE15: 0xF6 reads faults, 0xF7 thermal status.
// RULE16: Sleep bits power channels down, reset zero.
// RULE17: 0xFF and unknown codes are no-operations.
// RULE18: Non-updating broadcasts leave outputs unchanged.
package dscd_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_W = 32;
    localparam int DATA_W = 24;
    localparam int CODE_WIDE_LSB = 8;
    localparam int CODE_NARROW_LSB = 12;
    localparam int SET_LSB = 8;
    localparam int SLEEP_LSB = 8;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_WR_PWRDN = 8'h71;
    localparam logic [7:0] CMD_CODE_ALL = 8'h78;
    localparam logic [7:0] CMD_CODE_ALL_UPD = 8'h79;
    localparam logic [7:0] CMD_SET_ALL = 8'h7A;
    localparam logic [7:0] CMD_SET_ALL_UPD = 8'h7B;
    localparam logic [7:0] CMD_UPD_ALL = 8'h7C;
    localparam logic [7:0] CMD_NOP = 8'hFF;
    localparam logic [3:0] HI_UPD_CH = 4'h6;
    localparam logic [3:0] HI_RD_CODE = 4'h8;
    localparam logic [3:0] HI_RD_SET = 4'h9;
    localparam logic [3:0] HI_RD_OFS = 4'hA;
    localparam logic [3:0] HI_RD_GAIN = 4'hB;
    localparam logic [3:0] HI_RD_GLOBAL = 4'hF;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCK_PERIOD_NS = 40;
    localparam int HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [7:0] RST_CNT = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP,
        OP_CODE_ALL,
        OP_CODE_ALL_UPD,
        OP_SET_ALL,
        OP_SET_ALL_UPD,
        OP_UPD_ALL,
        OP_UPD_CH,
        OP_WR_PWRDN,
        OP_RD_CODE,
        OP_RD_SET,
        OP_RD_OFS,
        OP_RD_GAIN,
        OP_RD_GLOBAL
    } dscd_op_e;

    typedef struct packed {
        dscd_op_e op;
        logic [3:0] chan;
        logic [2:0] gsel;
        logic [15:0] wide_code_field;
        logic [11:0] settings;
        logic [7:0] channel_sleep_bits;
    } dscd_req_s;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic sdi;
    } dscd_pin_s;

endpackage

// [src/dscd_shift.sv]
/*
 * Serial frame engine: shifts one frame out MSB first on a divided clock and
 * captures the returned bits. Assumes the device samples on the rising serial
 * edge and changes its output on the falling one.
 */
`timescale 1ns/1ps
module dscd_shift
    import dscd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Frame request
    input wire logic start_i,
    input wire logic [FRAME_W-1:0] frame_i,
    output logic busy_o,
    output logic done_o,
    output logic [FRAME_W-1:0] rx_o,
    // Serial pins
    input wire logic sdo_i,
    output dscd_pin_s pin_o
);
    typedef enum logic [2:0] {SH_IDLE, SH_LEAD, SH_HIGH, SH_LOW, SH_GAP} dscd_sh_e;

    dscd_sh_e st;
    logic [7:0] cnt;
    logic [5:0] bits;
    logic [FRAME_W-1:0] shreg;
    logic sdo_meta;
    logic sdo_sync;
    logic sck;
    logic cs_n;
    logic sdi;
    logic half_end;

    // Two flops on the pin; only the second stage is read.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sdo_meta <= 1'b0;
            sdo_sync <= 1'b0;
        end else begin
            sdo_meta <= sdo_i;
            sdo_sync <= sdo_meta;
        end
    end

    assign half_end = (cnt == 8'(HALF_CYC - 1));

    // Divider counter restarts at every phase change.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || st == SH_IDLE || half_end) begin
            cnt <= RST_CNT;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // Phase sequencer. The sync delay equals a half period, so the
    // sample taken at the end of the high phase is settled device data.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= SH_IDLE;
            sck <= 1'b0;
            cs_n <= 1'b1;
            sdi <= 1'b0;
            bits <= 6'h00;
            shreg <= '0;
            rx_o <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (st)
                SH_IDLE: begin
                    if (start_i) begin
                        shreg <= frame_i;
                        sdi <= frame_i[FRAME_W-1];
                        cs_n <= 1'b0;
                        bits <= 6'h00;
                        st <= SH_LEAD;
                    end
                end
                SH_LEAD, SH_LOW: begin
                    if (half_end) begin
                        sck <= 1'b1;
                        st <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (half_end) begin
                        rx_o <= {rx_o[FRAME_W-2:0], sdo_sync};
                        sck <= 1'b0;
                        if (bits == 6'(FRAME_W - 1)) begin
                            st <= SH_GAP;
                        end else begin
                            shreg <= {shreg[FRAME_W-2:0], 1'b0};
                            sdi <= shreg[FRAME_W-2];
                            bits <= bits + 6'h01;
                            st <= SH_LOW;
                        end
                    end
                end
                SH_GAP: begin
                    cs_n <= 1'b1;
                    if (half_end) begin
                        done_o <= 1'b1;
                        st <= SH_IDLE;
                    end
                end
                default: begin
                    st <= SH_IDLE;
                end
            endcase
        end
    end

    assign busy_o = (st != SH_IDLE);
    assign pin_o = '{sck: sck, cs_n: cs_n, sdi: sdi};

endmodule

// [src/dscd_host.sv]
/*
 * Host controller that turns user requests into serial command frames for an
 * eight channel converter and returns read-back words.
 * Assumes one request at a time on a valid/ready handshake in the core clock
 * domain and a device that answers a read in the frame that follows it.
 */
`timescale 1ns/1ps
module dscd_host
    import dscd_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    // Device variant: high for the 16-bit part
    input wire logic WIDE_VARIANT_I,
    // Request
    input wire logic REQ_VALID_I,
    input wire dscd_req_s REQ_I,
    output logic REQ_READY_O,
    // Answer
    output logic DONE_O,
    output logic RSP_VALID_O,
    output logic [DATA_W-1:0] RSP_DATA_O,
    // Serial link
    input wire logic SDO_I,
    output logic SCK_O,
    output logic CS_N_O,
    output logic SDI_O
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {H_IDLE, H_CMD, H_FETCH} dscd_st_e;

    dscd_st_e st;
    dscd_req_s req_q;
    logic wide_q;
    logic accept;
    logic is_read;
    logic read_q;
    logic start;
    logic [FRAME_W-1:0] next_frame;
    logic [FRAME_W-1:0] frame_q;
    logic [FRAME_W-1:0] start_frame;
    logic sh_busy;
    logic sh_done;
    logic [FRAME_W-1:0] sh_rx;
    dscd_pin_s pins;
    logic [7:0] next_cmd;
    logic [DATA_W-1:0] next_data;

    // ----------------------------------------------------------------
    // Frame builder
    // ----------------------------------------------------------------
    // Maps an operation to its command byte and data word. Anything not
    // recognised goes out as the no-operation code so the device ignores it.
    always_comb begin
        next_cmd = CMD_NOP;
        next_data = '0;
        case (REQ_I.op)
            OP_CODE_ALL, OP_CODE_ALL_UPD: begin
                next_cmd = (REQ_I.op == OP_CODE_ALL) ? CMD_CODE_ALL : CMD_CODE_ALL_UPD; // see RULE3 see RULE18
                if (WIDE_VARIANT_I) begin
                    next_data[CODE_WIDE_LSB +: 16] = REQ_I.wide_code_field; // see RULE1
                end else begin
                    next_data[CODE_NARROW_LSB +: 12] = REQ_I.wide_code_field[11:0]; // see RULE2
                end
            end
            OP_SET_ALL, OP_SET_ALL_UPD: begin
                next_cmd = (REQ_I.op == OP_SET_ALL) ? CMD_SET_ALL : CMD_SET_ALL_UPD; // see RULE4 see RULE5
                next_data[SET_LSB +: 12] = REQ_I.settings;
            end
            OP_UPD_ALL: begin
                next_cmd = CMD_UPD_ALL; // see RULE6
            end
            OP_UPD_CH: begin
                next_cmd = {HI_UPD_CH, REQ_I.chan}; // see RULE7
            end
            OP_WR_PWRDN: begin
                next_cmd = CMD_WR_PWRDN;
                next_data[SLEEP_LSB +: 8] = REQ_I.channel_sleep_bits; // see RULE16
            end
            OP_RD_CODE: begin
                next_cmd = {HI_RD_CODE, REQ_I.chan}; // see RULE8
            end
            OP_RD_SET: begin
                next_cmd = {HI_RD_SET, REQ_I.chan}; // see RULE9
            end
            OP_RD_OFS: begin
                next_cmd = {HI_RD_OFS, REQ_I.chan}; // see RULE10
            end
            OP_RD_GAIN: begin
                next_cmd = {HI_RD_GAIN, REQ_I.chan}; // see RULE11
            end
            OP_RD_GLOBAL: begin
                // Selects 0 to 7 reach the eight global read codes.
                next_cmd = {HI_RD_GLOBAL, 1'b0, REQ_I.gsel}; // see RULE12 see RULE13 see RULE14 see RULE15
            end
            default: begin
                next_cmd = CMD_NOP; // see RULE17
            end
        endcase
        next_frame = {next_cmd, next_data};
    end

    assign is_read = (REQ_I.op == OP_RD_CODE) || (REQ_I.op == OP_RD_SET) ||
                     (REQ_I.op == OP_RD_OFS) || (REQ_I.op == OP_RD_GAIN) ||
                     (REQ_I.op == OP_RD_GLOBAL);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Ready only while idle and the engine has finished its gap, so a
    // request is never dropped and frames never overlap.
    assign REQ_READY_O = (st == H_IDLE) && !sh_busy;
    assign accept = REQ_VALID_I && REQ_READY_O;

    // A read needs a trailing no-operation frame to clock its answer out.
    assign start = accept || (st == H_CMD && sh_done && read_q);
    assign start_frame = accept ? next_frame : {CMD_NOP, {DATA_W{1'b0}}};

    // Request capture, kept for the checks below and for the read flag.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            req_q <= '0;
            frame_q <= '0;
            read_q <= 1'b0;
            wide_q <= 1'b0;
        end else if (accept) begin
            req_q <= REQ_I;
            frame_q <= next_frame;
            read_q <= is_read;
            wide_q <= WIDE_VARIANT_I;
        end
    end

    // State of the request in flight.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            st <= H_IDLE;
        end else begin
            case (st)
                H_IDLE: begin
                    if (accept) begin
                        st <= H_CMD;
                    end
                end
                H_CMD: begin
                    if (sh_done) begin
                        st <= read_q ? H_FETCH : H_IDLE;
                    end
                end
                H_FETCH: begin
                    if (sh_done) begin
                        st <= H_IDLE;
                    end
                end
                default: begin
                    st <= H_IDLE;
                end
            endcase
        end
    end

    // Answer outputs. DONE_O closes every request; a read also raises
    // RSP_VALID_O with the word from the trailing frame.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            DONE_O <= 1'b0;
            RSP_VALID_O <= 1'b0;
            RSP_DATA_O <= '0;
        end else begin
            DONE_O <= sh_done && ((st == H_CMD && !read_q) || st == H_FETCH);
            RSP_VALID_O <= sh_done && (st == H_FETCH);
            if (sh_done && st == H_FETCH) begin
                RSP_DATA_O <= sh_rx[DATA_W-1:0]; // see RULE8 see RULE12
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial engine
    // ----------------------------------------------------------------
    dscd_shift u_shift (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESETN_I),
        .start_i(start),
        .frame_i(start_frame),
        .busy_o(sh_busy),
        .done_o(sh_done),
        .rx_o(sh_rx),
        .sdo_i(SDO_I),
        .pin_o(pins)
    );

    assign SCK_O = pins.sck;
    assign CS_N_O = pins.cs_n;
    assign SDI_O = pins.sdi;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    property p_code_wide;
        accept && REQ_I.op == OP_CODE_ALL && WIDE_VARIANT_I |=>
            frame_q[31:24] == 8'h78 && frame_q[23:8] == $past(REQ_I.wide_code_field);
    endproperty
    a_code_wide: assert property (p_code_wide) else $error("wide broadcast code misplaced"); // see RULE1

    property p_code_narrow;
        accept && REQ_I.op == OP_CODE_ALL && !WIDE_VARIANT_I |=>
            frame_q[23:12] == req_q.wide_code_field[11:0] && frame_q[11:0] == 12'h000;
    endproperty
    a_code_narrow: assert property (p_code_narrow) else $error("narrow broadcast code misplaced"); // see RULE2

    property p_code_upd;
        accept && REQ_I.op == OP_CODE_ALL_UPD |=> frame_q[31:24] == 8'h79 &&
            (wide_q ? frame_q[23:8] == req_q.wide_code_field
                    : frame_q[23:12] == req_q.wide_code_field[11:0]);
    endproperty
    a_code_upd: assert property (p_code_upd) else $error("code-and-update frame wrong"); // see RULE3

    property p_set_all;
        accept && (REQ_I.op == OP_SET_ALL || REQ_I.op == OP_SET_ALL_UPD) |=>
            frame_q[19:8] == req_q.settings && frame_q[23:20] == 4'h0 &&
            frame_q[31:24] == ((req_q.op == OP_SET_ALL) ? 8'h7A : 8'h7B);
    endproperty
    a_set_all: assert property (p_set_all) else $error("settings broadcast frame wrong"); // see RULE4

    property p_upd_all;
        accept && REQ_I.op == OP_UPD_ALL |=> frame_q == 32'h7C00_0000;
    endproperty
    a_upd_all: assert property (p_upd_all) else $error("update-all frame carries data"); // see RULE6

    property p_read_chan;
        accept && REQ_I.op inside {OP_RD_CODE, OP_RD_SET, OP_RD_OFS, OP_RD_GAIN} |=>
            frame_q[27:24] == req_q.chan && frame_q[31:28] == 4'(4'h8 + (req_q.op - OP_RD_CODE));
    endproperty
    a_read_chan: assert property (p_read_chan) else $error("channel read code wrong"); // see RULE8

    property p_read_global;
        accept && REQ_I.op == OP_RD_GLOBAL |=> frame_q[31:24] == {5'h1E, req_q.gsel};
    endproperty
    a_read_global: assert property (p_read_global) else $error("global read code wrong"); // see RULE12

    property p_nop;
        accept && REQ_I.op == OP_NOP |=> frame_q == 32'hFF00_0000;
    endproperty
    a_nop: assert property (p_nop) else $error("no-operation frame wrong"); // see RULE17

    property p_read_answer;
        accept && is_read |-> ##[200:300] RSP_VALID_O;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer missing"); // see RULE9

    // Starts one cycle late: a back-to-back accept may share its cycle with the previous read's answer pulse.
    property p_write_quiet;
        accept && !is_read |=> !RSP_VALID_O [*8] ##[100:200] DONE_O;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("write finished badly"); // see RULE18

    property p_cs_frame;
        $fell(CS_N_O) |-> !CS_N_O [*8];
    endproperty
    a_cs_frame: assert property (p_cs_frame) else $error("select released mid-frame"); // see RULE5

    c_write: cover property (accept && REQ_I.op == OP_CODE_ALL_UPD ##[1:200] DONE_O);
    c_read: cover property (accept && REQ_I.op == OP_RD_GLOBAL ##[1:300] RSP_VALID_O);
    c_upd_ch: cover property (accept && REQ_I.op == OP_UPD_CH);
    c_back: cover property (DONE_O ##1 accept);

endmodule

// [testbench/dscd_dev_model.sv]
/*
 * Behavioural model of the eight channel converter as seen over its serial pins.
 * Assumes 32-bit frames, MSB first, sampled on the rising serial edge, with a read
 * answered in the low 24 bits of the frame that follows it.
 */
`timescale 1ns/1ps
module dscd_dev_model (
    // Core clock, used only to time the select gap
    input wire logic clk_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic sdo_o,
    // Observation
    output logic [31:0] last_frame_o,
    output logic [7:0] gap_err_o
);
    // ----------------------------------------
    // Channel state
    // ----------------------------------------
    logic [15:0] in_c [8];
    logic [15:0] out_c [8];
    logic [11:0] set_v [8];
    logic [15:0] sleep;
    logic [23:0] reply;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [7:0] c;
    logic [2:0] lo;
    int cnt;
    int gap;

    // Channel state, reply and outputs start cleared, as after a power-on reset; the gap count starts at 100.
    initial begin
        for (int i = 0; i < 8; i++) begin
            in_c[i] = 16'h0000;
            out_c[i] = 16'h0000;
            set_v[i] = 12'h000;
        end
        sleep = 16'h0000;
        reply = 24'h000000;
        cnt = 0;
        gap = 100;
        gap_err_o = 8'h00;
        sdo_o = 1'b0;
        last_frame_o = 32'h00000000;
    end

    // ----------------------------------------
    // Serial shifting
    // ----------------------------------------
    // Core cycles with select high, so a too short gap is caught. Blocking, so the
    // count is settled before a select fall launched by the same edge is seen.
    always @(posedge clk_i) begin
        gap = cs_n_i ? gap + 1 : 0;
    end

    // A new frame loads the pending answer of the previous command.
    always @(negedge cs_n_i) begin
        if (gap < 2) gap_err_o++;
        cnt = 0;
        tx = {8'h00, reply};
        sdo_o = tx[31];
    end

    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            rx = {rx[30:0], sdi_i};
            cnt++;
        end
    end

    always @(negedge sck_i) begin
        if (!cs_n_i) begin
            tx = {tx[30:0], 1'b0};
            sdo_o = tx[31];
        end
    end

    // ----------------------------------------
    // Command execution at frame end
    // ----------------------------------------
    // A frame cut short is dropped whole; on release the line flips to the inverse of its last bit.
    always @(posedge cs_n_i) begin
        sdo_o = ~sdo_o;
        if (cnt == 32) begin
            c = rx[31:24];
            lo = c[2:0];
            last_frame_o = rx;
            reply = 24'h000000;
            if (c == 8'h71) sleep = rx[23:8];
            for (int i = 0; i < 8; i++) begin
                if (c == 8'h78 || c == 8'h79) in_c[i] = rx[23:8];
                if (c == 8'h7A || c == 8'h7B) set_v[i] = rx[19:8];
                if (c == 8'h79 || c == 8'h7B || c == 8'h7C) out_c[i] = in_c[i];
            end
            if (c[7:4] == 4'h6) out_c[lo] = in_c[lo];
            case (c[7:4])
                4'h8: reply = {out_c[lo], 8'h00};
                4'h9: reply = {4'h0, set_v[lo], 8'h00};
                4'hA: reply = 24'hA00000 + 24'(lo);
                4'hB: reply = 24'hB00000 + 24'(lo);
                4'hF: begin
                    if (c == 8'hF1) reply = {sleep, 8'h00};
                    else if (c != 8'hFF) reply = 24'hC00000 + 24'(c[3:0]);
                end
                default: ;
            endcase
        end
    end
endmodule

// [testbench/dscd_host_tb_top.sv]
/*
 * Self-checking bench of the host command controller against the device model.
 * Assumes the design's hand-over timing: 131 cycles per write, two frames per read.
 */
`timescale 1ns/1ps
module dscd_host_tb_top
    import dscd_pkg::*;
;
    typedef struct {
        dscd_req_s r;
        logic w;
        int k;
        logic [31:0] e;
    } dscd_row_s;

    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wide = 1'b1;
    logic req_valid = 1'b0;
    dscd_req_s req = '0;
    logic req_ready;
    logic done;
    logic rsp_valid;
    logic [23:0] rsp_data;
    logic sdo;
    logic sck;
    logic cs_n;
    logic sdi;
    logic [31:0] last_frame;
    logic [7:0] gap_err;
    dscd_row_s rows[$];
    int error_cnt = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    dscd_host dscd_host_i (.CORE_CLK_I(clk), .RESETN_I(rst_n), .WIDE_VARIANT_I(wide), .REQ_VALID_I(req_valid),
        .REQ_I(req), .REQ_READY_O(req_ready), .DONE_O(done), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
        .SDO_I(sdo), .SCK_O(sck), .CS_N_O(cs_n), .SDI_O(sdi));

    dscd_dev_model dscd_dev_model_i (.clk_i(clk), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo),
        .last_frame_o(last_frame), .gap_err_o(gap_err));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask

    function automatic void add(dscd_op_e op, logic [3:0] ch, logic [2:0] g, logic [15:0] cd, logic [11:0] st,
        logic [7:0] sl, logic w, int k, logic [31:0] e);
        dscd_row_s x;
        x.r = '{op: op, chan: ch, gsel: g, wide_code_field: cd, settings: st, channel_sleep_bits: sl};
        x.w = w;
        x.k = k;
        x.e = e;
        rows.push_back(x);
    endfunction

    // Kind 1 checks the whole frame, 2 the read word, 3 only the command byte.
    task automatic run(input dscd_row_s x);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= x.r;
        wide <= x.w;
        n = 0;
        do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 400);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 5) chk("ready while busy", 32'h0, {31'h0, req_ready});
        end while (done !== 1'b1 && n < 400);
        if (x.k == 2) begin
            chk("read valid", 32'h1, {31'h0, rsp_valid});
            chk("read word", x.e, {8'h00, rsp_data});
            chk("read time", 32'h1, {31'h0, (n > 200 && n < 302)});
        end else begin
            chk("write time", 32'd132, 32'(n));
        end
        if (x.k == 1) chk("frame", x.e, last_frame);
        if (x.k == 3) chk("command", {24'h0, x.e[31:24]}, {24'h0, last_frame[31:24]});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        add(OP_RD_SET, 0, 0, 0, 0, 0, 1, 2, 32'h000000);
        add(OP_RD_GLOBAL, 0, 1, 0, 0, 0, 1, 2, 32'h000000);
        add(OP_CODE_ALL, 0, 0, 16'h1234, 0, 0, 1, 1, 32'h78123400);
        add(OP_RD_CODE, 3, 0, 0, 0, 0, 1, 2, 32'h000000);
        add(OP_UPD_CH, 3, 0, 0, 0, 0, 1, 3, 32'h63000000);
        add(OP_RD_CODE, 3, 0, 0, 0, 0, 1, 2, 32'h123400);
        add(OP_RD_CODE, 2, 0, 0, 0, 0, 1, 2, 32'h000000);
        add(OP_UPD_ALL, 0, 0, 0, 0, 0, 1, 3, 32'h7C000000);
        add(OP_RD_CODE, 2, 0, 0, 0, 0, 1, 2, 32'h123400);
        add(OP_CODE_ALL_UPD, 0, 0, 16'hBEEF, 0, 0, 1, 1, 32'h79BEEF00);
        add(OP_RD_CODE, 7, 0, 0, 0, 0, 1, 2, 32'hBEEF00);
        add(OP_CODE_ALL_UPD, 0, 0, 16'h0123, 0, 0, 0, 1, 32'h79123000);
        add(OP_CODE_ALL, 0, 0, 16'h0ABC, 0, 0, 0, 1, 32'h78ABC000);
        add(OP_RD_CODE, 0, 0, 0, 0, 0, 0, 2, 32'h123000);
        add(OP_UPD_ALL, 0, 0, 0, 0, 0, 0, 3, 32'h7C000000);
        add(OP_RD_CODE, 0, 0, 0, 0, 0, 0, 2, 32'hABC000);
        add(OP_SET_ALL, 0, 0, 0, 12'h5A3, 0, 1, 1, 32'h7A05A300);
        add(OP_RD_SET, 4, 0, 0, 0, 0, 1, 2, 32'h05A300);
        add(OP_CODE_ALL, 0, 0, 16'h7777, 0, 0, 1, 1, 32'h78777700);
        add(OP_SET_ALL_UPD, 0, 0, 0, 12'h3C1, 0, 1, 1, 32'h7B03C100);
        add(OP_RD_CODE, 5, 0, 0, 0, 0, 1, 2, 32'h777700);
        add(OP_RD_SET, 1, 0, 0, 0, 0, 1, 2, 32'h03C100);
        add(OP_RD_OFS, 6, 0, 0, 0, 0, 1, 2, 32'hA00006);
        add(OP_RD_GAIN, 6, 0, 0, 0, 0, 1, 2, 32'hB00006);
        add(OP_WR_PWRDN, 0, 0, 0, 0, 8'h96, 1, 1, 32'h71009600);
        for (int g = 0; g < 8; g++) begin
            add(OP_RD_GLOBAL, 0, 3'(g), 0, 0, 0, 1, 2, (g == 1) ? 32'h009600 : 32'hC00000 + g);
        end
        add(OP_NOP, 0, 0, 0, 0, 0, 1, 1, 32'hFF000000);
        add(dscd_op_e'(4'hD), 0, 0, 0, 0, 0, 1, 1, 32'hFF000000);
        add(OP_RD_CODE, 5, 0, 0, 0, 0, 1, 2, 32'h777700);
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("idle pins in reset", 32'h5, {29'h0, cs_n, sck, req_ready});
        chk("idle answer in reset", 32'h0, {7'h0, done, rsp_data});
        @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        // A reset in mid-frame must leave the link idle and the device untouched.
        @(posedge clk);
        req_valid <= 1'b1;
        req <= rows[9].r;
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (40) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("pins after abort", 32'h5, {29'h0, cs_n, sck, req_ready});
        @(posedge clk);
        rst_n <= 1'b1;
        run(rows[rows.size() - 1]);
        chk("select gap", 32'h0, {24'h0, gap_err});
        test_done();
    end

    // Cuts a hang short, well beyond the expected run of about 8100 cycles.
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule
